// ---- verilog/tpl_params.svh ----
// Summary of operation
// R1: A trigger event (first latch input, second latch input or encoder zero pulse) captures the feedback position.
// R2: Two latch channels run side by side and may be armed and capture in the same cycle.
// R3: Channel one is steered by the low byte of the probe control object written by the master.
// R4: Channel one reports its state in the low byte of the probe state object.
// R5: Every capture of channel one is stored as a signed 32-bit value in captured position one.
// R6: Channel one triggers on the encoder zero pulse or on the first latch input, as its control byte selects.
// R7: Channel two is steered by the high byte of the probe control object written by the master.
// R8: Channel two reports its state in the high byte of the probe state object.
// R9: Channel two triggers only on the second latch input and stores its capture in captured position two.
// R10: The master does not use channel one while homing runs.
// R11: When homing starts with channel one active, channel one is switched off.
// R12: With control bit 1 or bit 9 clear the channel captures only the first event after arming.
// R13: With control bit 1 or bit 9 set the channel captures on every trigger event.
// R14: Pin routing and active polarity of both latch inputs are chosen by a configuration input.
// R15: A capture sets the latched flag, and in single mode further events are ignored until re-armed.
// R16: Clearing an enable bit disarms the channel and clears its flags while the captured value is kept.
`ifndef TPL_PARAMS_SVH
`define TPL_PARAMS_SVH

// Object indices
`define TPL_IDX_CTRL   16'h60b8
`define TPL_IDX_STATUS 16'h60b9
`define TPL_IDX_POS1   16'h60ba
`define TPL_IDX_POS2   16'h60bc

// Control byte fields, same layout in both bytes
`define TPL_CB_EN   0
`define TPL_CB_CONT 1
`define TPL_CB_SRC  2

// Channel two control bits in the full control word
`define TPL_CH2_BASE_EN   8
`define TPL_CH2_BASE_CONT 9

// State byte fields
`define TPL_SB_EN      0
`define TPL_SB_LATCHED 1
`define TPL_SB_TOGGLE  7

// Channel two state bits in the full state word, and the bits that always read 0
`define TPL_SB2_LATCHED 9
`define TPL_SB2_TOGGLE  15
`define TPL_STAT_UNUSED 16'h7c7c

// Routing nibble of the input configuration
`define TPL_CFG_POL     0
`define TPL_CFG_SEL_LSB 1
`define TPL_CFG_SEL_MSB 2
`define TPL_CFG_ONE_LSB 0
`define TPL_CFG_ONE_MSB 3
`define TPL_CFG_TWO_LSB 4
`define TPL_CFG_TWO_MSB 7

// Reset values
`define TPL_CTRL_RST 16'h0000
`define TPL_STAT_RST 16'h0000
`define TPL_POS_RST  32'h0000_0000
`define TPL_DATA_RST 32'h0000_0000

`endif

// ---- verilog/tpl_pkg.sv ----
package tpl_pkg;

   typedef enum logic [1:0] {
      TPL_IDLE,
      TPL_ARMED,
      TPL_DONE
   } tpl_chan_mode_t;

   typedef struct packed {
      tpl_chan_mode_t mode;
      logic           latched;
      logic           toggle;
   } tpl_chan_t;

   typedef struct packed {
      logic [15:0] index;
      logic        wr;
      logic        rd;
      logic [31:0] wdata;
   } tpl_obj_req_t;

   typedef struct packed {
      logic        ack;
      logic        hit;
      logic [31:0] rdata;
   } tpl_obj_rsp_t;

   typedef struct packed {
      logic [15:0]  ctrl;
      logic [15:0]  status;
      tpl_chan_t    ch1;
      tpl_chan_t    ch2;
      logic [31:0]  pos1;
      logic [31:0]  pos2;
      logic         zero_prev;
      tpl_obj_rsp_t rsp;
   } tpl_state_t;

   typedef struct packed {
      logic lvl_prev;
   } tpl_trig_state_t;

endpackage

// ---- verilog/tpl_trig_cond.sv ----
`timescale 1ns/1ps
`include "tpl_params.svh"

module tpl_trig_cond (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Pins and routing
   input  wire logic [3:0] pins,
   input  wire logic [3:0] cfg,
   // Event
   output logic            edge_pulse
);

   tpl_pkg::tpl_trig_state_t s_reg;
   tpl_pkg::tpl_trig_state_t s_next;
   logic                     act_lvl;

   // Routed pin, inverted when the input is active low
   assign act_lvl = pins[cfg[`TPL_CFG_SEL_MSB:`TPL_CFG_SEL_LSB]] ^ cfg[`TPL_CFG_POL]; // R14

   // Active edge only, so a held level does not retrigger continuous mode
   assign edge_pulse = act_lvl & ~s_reg.lvl_prev;

   always_comb begin
      s_next          = s_reg;
      s_next.lvl_prev = act_lvl;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_reg.lvl_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   pulse_polarity_a : assert property ( // R14
      edge_pulse |-> ((pins[cfg[`TPL_CFG_SEL_MSB:`TPL_CFG_SEL_LSB]] ^ cfg[`TPL_CFG_POL]) == 1'b1)
      && !$past(act_lvl))
      else $error("Latch event without an active edge");

endmodule

// ---- verilog/tpl_latch.sv ----
`timescale 1ns/1ps
`include "tpl_params.svh"

module tpl_latch (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // Latch pins and routing
   input  wire logic [3:0]           latch_pins,
   input  wire logic [7:0]           latch_input_config_param,
   input  wire logic                 enc_zero,
   // Drive state
   input  wire logic                 homing_active,
   input  wire logic signed [31:0]   fb_position,
   // Object access
   input  wire tpl_pkg::tpl_obj_req_t obj_req,
   output tpl_pkg::tpl_obj_rsp_t     obj_rsp,
   // Mapped objects
   output logic [15:0]               probe_control,
   output logic [15:0]               probe_state,
   output logic signed [31:0]        captured_position_one,
   output logic signed [31:0]        captured_position_two
);

   tpl_pkg::tpl_state_t s_reg;
   tpl_pkg::tpl_state_t s_next;

   logic latch_input_one;
   logic latch_input_two;
   logic zero_edge;
   logic ev1;
   logic ev2;
   logic cap1;
   logic cap2;
   logic ctrl_wr;
   logic cont1;
   logic cont2;

   // Capture is possible only from the armed state
   function automatic logic chan_cap(input tpl_pkg::tpl_chan_t cur, input logic ev);
      chan_cap = (cur.mode == tpl_pkg::TPL_ARMED) && ev; // R1
   endfunction

   function automatic tpl_pkg::tpl_chan_t chan_next(
      input tpl_pkg::tpl_chan_t cur,
      input logic               old_en,
      input logic [7:0]         new_cb,
      input logic               wr,
      input logic               cap,
      input logic               kill
   );
      tpl_pkg::tpl_chan_t n;
      n = cur;
      if (wr && !new_cb[`TPL_CB_EN]) begin
         n.mode    = tpl_pkg::TPL_IDLE; // R16
         n.latched = 1'b0;
         n.toggle  = 1'b0;
      end else if (wr && !old_en) begin
         n.mode    = tpl_pkg::TPL_ARMED; // R15
         n.latched = 1'b0;
         n.toggle  = 1'b0;
      end
      // Hardware set wins over a same-cycle clear by the master
      if (cap) begin
         n.latched = 1'b1; // R15
         n.toggle  = ~cur.toggle;
         if (!new_cb[`TPL_CB_CONT] && new_cb[`TPL_CB_EN] && n.mode == tpl_pkg::TPL_ARMED) begin // R13
            n.mode = tpl_pkg::TPL_DONE; // R12
         end
      end
      if (kill) begin
         n.mode    = tpl_pkg::TPL_IDLE; // R11
         n.latched = 1'b0;
         n.toggle  = 1'b0;
      end
      chan_next = n;
   endfunction

   // State byte of one channel
   function automatic logic [7:0] stat_byte(input tpl_pkg::tpl_chan_t c);
      logic [7:0] b;
      b                  = 8'h00;
      b[`TPL_SB_EN]      = (c.mode != tpl_pkg::TPL_IDLE);
      b[`TPL_SB_LATCHED] = c.latched;
      b[`TPL_SB_TOGGLE]  = c.toggle;
      stat_byte          = b;
   endfunction

   tpl_trig_cond u_cond_one (
      .core_clk   (core_clk),
      .rst        (rst),
      .pins       (latch_pins),
      .cfg        (latch_input_config_param[`TPL_CFG_ONE_MSB:`TPL_CFG_ONE_LSB]),
      .edge_pulse (latch_input_one)
   );

   tpl_trig_cond u_cond_two (
      .core_clk   (core_clk),
      .rst        (rst),
      .pins       (latch_pins),
      .cfg        (latch_input_config_param[`TPL_CFG_TWO_MSB:`TPL_CFG_TWO_LSB]),
      .edge_pulse (latch_input_two)
   );

   assign zero_edge = enc_zero & ~s_reg.zero_prev;
   assign ctrl_wr   = obj_req.wr && (obj_req.index == `TPL_IDX_CTRL);
   assign ev1       = s_reg.ctrl[`TPL_CB_SRC] ? zero_edge : latch_input_one; // R6
   assign ev2       = latch_input_two; // R9
   // Homing takes channel one away even in the capture cycle
   assign cap1      = chan_cap(s_reg.ch1, ev1) && !homing_active; // R10
   assign cap2      = chan_cap(s_reg.ch2, ev2); // R2
   assign cont1     = s_reg.ctrl[`TPL_CB_CONT];
   assign cont2     = s_reg.ctrl[`TPL_CH2_BASE_CONT];

   always_comb begin
      s_next           = s_reg;
      s_next.zero_prev = enc_zero;
      if (ctrl_wr) begin
         s_next.ctrl = obj_req.wdata[15:0]; // R3 R7
      end
      if (homing_active) begin
         s_next.ctrl[`TPL_CB_EN] = 1'b0; // R11
      end
      s_next.ch1 = chan_next(s_reg.ch1, s_reg.ctrl[`TPL_CB_EN], s_next.ctrl[7:0],
                             ctrl_wr, cap1, homing_active); // R3
      s_next.ch2 = chan_next(s_reg.ch2, s_reg.ctrl[`TPL_CH2_BASE_EN], s_next.ctrl[15:8],
                             ctrl_wr, cap2, 1'b0); // R7
      if (cap1) begin
         s_next.pos1 = fb_position; // R5
      end
      if (cap2) begin
         s_next.pos2 = fb_position; // R9
      end
      s_next.status = {stat_byte(s_next.ch2), stat_byte(s_next.ch1)}; // R4 R8
      // One-cycle answer to every access, hit only for a known object
      s_next.rsp.ack   = obj_req.wr | obj_req.rd;
      s_next.rsp.hit   = 1'b0;
      s_next.rsp.rdata = `TPL_DATA_RST;
      if (obj_req.wr) begin
         s_next.rsp.hit = ctrl_wr;
      end else if (obj_req.rd) begin
         unique case (obj_req.index)
            `TPL_IDX_CTRL: begin
               s_next.rsp.hit   = 1'b1;
               s_next.rsp.rdata = {16'h0000, s_reg.ctrl};
            end
            `TPL_IDX_STATUS: begin
               s_next.rsp.hit   = 1'b1;
               s_next.rsp.rdata = {16'h0000, s_reg.status}; // R4 R8
            end
            `TPL_IDX_POS1: begin
               s_next.rsp.hit   = 1'b1;
               s_next.rsp.rdata = s_reg.pos1;
            end
            `TPL_IDX_POS2: begin
               s_next.rsp.hit   = 1'b1;
               s_next.rsp.rdata = s_reg.pos2;
            end
            default: begin
               s_next.rsp.hit   = 1'b0;
               s_next.rsp.rdata = `TPL_DATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_reg.ctrl      <= `TPL_CTRL_RST;
         s_reg.status    <= `TPL_STAT_RST;
         s_reg.ch1       <= '{mode: tpl_pkg::TPL_IDLE, latched: 1'b0, toggle: 1'b0};
         s_reg.ch2       <= '{mode: tpl_pkg::TPL_IDLE, latched: 1'b0, toggle: 1'b0};
         s_reg.pos1      <= `TPL_POS_RST;
         s_reg.pos2      <= `TPL_POS_RST;
         s_reg.zero_prev <= 1'b1;
         s_reg.rsp       <= '{ack: 1'b0, hit: 1'b0, rdata: `TPL_DATA_RST};
      end else begin
         s_reg <= s_next;
      end
   end

   assign obj_rsp               = s_reg.rsp;
   assign probe_control         = s_reg.ctrl;
   assign probe_state           = s_reg.status;
   assign captured_position_one = s_reg.pos1;
   assign captured_position_two = s_reg.pos2;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_single_cap1;
      cap1 && !cont1 && !ctrl_wr;
   endsequence

   sequence s_new_event1;
      ev1 && !ctrl_wr && !homing_active;
   endsequence

   homing_switch_off_a : assert property ( // R11
      homing_active |=> !probe_control[`TPL_CB_EN] && !probe_state[`TPL_SB_EN])
      else $error("Channel one still active during homing");

   single_then_hold_a : assert property ( // R12
      s_single_cap1 ##1 s_new_event1 |=> $stable(captured_position_one) && probe_state[`TPL_SB_LATCHED])
      else $error("Single mode captured a second event");

   cont_stays_armed_a : assert property ( // R13
      cap2 && cont2 && !ctrl_wr |=> s_reg.ch2.mode == tpl_pkg::TPL_ARMED)
      else $error("Continuous channel two left the armed state");

   pos_one_capture_a : assert property ( // R5
      cap1 |=> captured_position_one == $past(fb_position))
      else $error("Captured position one mismatch");

   pos_two_source_a : assert property ( // R9
      (s_reg.ch2.mode == tpl_pkg::TPL_ARMED) && latch_input_two && !ctrl_wr
      |=> captured_position_two == $past(fb_position) && probe_state[`TPL_SB2_LATCHED])
      else $error("Channel two missed its latch input");

   zero_source_a : assert property ( // R6
      (s_reg.ch1.mode == tpl_pkg::TPL_ARMED) && s_reg.ctrl[`TPL_CB_SRC] && zero_edge && !homing_active
      |=> captured_position_one == $past(fb_position))
      else $error("Channel one missed the zero pulse");

   both_capture_a : assert property ( // R2
      cap1 && cap2 |=> probe_state[`TPL_SB_LATCHED] && probe_state[`TPL_SB2_LATCHED])
      else $error("Concurrent captures not both flagged");

   disarm_keeps_pos_a : assert property ( // R16
      ctrl_wr && !obj_req.wdata[`TPL_CB_EN] && !cap1
      |=> probe_state[7:0] == 8'h00 && $stable(captured_position_one))
      else $error("Disable did not clear channel one");

   ctrl_write_a : assert property ( // R3 R7
      ctrl_wr && !homing_active |=> probe_control == $past(obj_req.wdata[15:0]))
      else $error("Control object not written");

   status_read_a : assert property ( // R4 R8
      obj_req.rd && !obj_req.wr && obj_req.index == `TPL_IDX_STATUS
      |=> obj_rsp.ack && obj_rsp.hit && obj_rsp.rdata[15:0] == $past(probe_state))
      else $error("State object read mismatch");

   ctrl_read_a : assert property ( // R3
      obj_req.rd && !obj_req.wr && obj_req.index == `TPL_IDX_CTRL
      |=> obj_rsp.hit && obj_rsp.rdata == {16'h0000, $past(probe_control)})
      else $error("Control object read mismatch");

   ack_one_cycle_a : assert property ( // R3
      obj_rsp.ack == $past(obj_req.wr || obj_req.rd))
      else $error("Access answer not exactly one cycle later");

   refused_write_a : assert property ( // R3
      obj_req.wr && obj_req.index != `TPL_IDX_CTRL && !homing_active
      |=> $stable(probe_control) && obj_rsp.ack && !obj_rsp.hit)
      else $error("Write to a read-only object took effect");

   miss_reads_zero_a : assert property ( // R4
      obj_rsp.ack && !obj_rsp.hit |-> obj_rsp.rdata == `TPL_DATA_RST)
      else $error("Refused access returned data");

   state_spare_zero_a : assert property ( // R4 R8
      (probe_state & `TPL_STAT_UNUSED) == 16'h0000)
      else $error("Unused state bits not zero");

   homing_holds_one_a : assert property ( // R11
      homing_active |=> $stable(captured_position_one))
      else $error("Channel one captured during homing");

   arm_one_a : assert property ( // R15
      ctrl_wr && obj_req.wdata[`TPL_CB_EN] && !probe_control[`TPL_CB_EN] && !homing_active
      |=> probe_state[`TPL_SB_EN] && !probe_state[`TPL_SB_LATCHED])
      else $error("Channel one not armed by enable write");

   arm_two_a : assert property ( // R7
      ctrl_wr && obj_req.wdata[`TPL_CH2_BASE_EN] && !probe_control[`TPL_CH2_BASE_EN]
      |=> s_reg.ch2.mode == tpl_pkg::TPL_ARMED)
      else $error("Channel two not armed by enable write");

   toggle_one_a : assert property ( // R15
      cap1 |=> probe_state[`TPL_SB_TOGGLE] != $past(probe_state[`TPL_SB_TOGGLE]))
      else $error("Channel one toggle did not flip");

   toggle_two_a : assert property ( // R15
      cap2 |=> probe_state[`TPL_SB2_TOGGLE] != $past(probe_state[`TPL_SB2_TOGGLE]))
      else $error("Channel two toggle did not flip");

   cont_one_armed_a : assert property ( // R13
      cap1 && cont1 && !ctrl_wr |=> s_reg.ch1.mode == tpl_pkg::TPL_ARMED)
      else $error("Continuous channel one left the armed state");

   single_two_done_a : assert property ( // R12
      cap2 && !cont2 && !ctrl_wr |=> s_reg.ch2.mode == tpl_pkg::TPL_DONE)
      else $error("Single channel two still armed after capture");

   pos_two_zero_a : assert property ( // R9
      zero_edge && !latch_input_two |=> $stable(captured_position_two))
      else $error("Channel two captured on the zero pulse");

   idle_holds_one_a : assert property ( // R15
      s_reg.ch1.mode != tpl_pkg::TPL_ARMED |=> $stable(captured_position_one))
      else $error("Unarmed channel one captured");

endmodule

// ---- tb/tpl_master_model.sv ----
`timescale 1ns/1ps

module tpl_master_model (
   // Clock
   input  wire logic                  core_clk,
   // Object access
   output tpl_pkg::tpl_obj_req_t      obj_req,
   input  wire tpl_pkg::tpl_obj_rsp_t obj_rsp
);
   initial begin
      obj_req = '0;
   end

   // One request per call, held across the taking edge only
   task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                         output logic ack, output logic hit, output logic [31:0] rd);
      @(negedge core_clk);
      obj_req.index = idx;
      obj_req.wdata = wd;
      obj_req.wr    = wr;
      obj_req.rd    = ~wr;
      @(negedge core_clk);
      ack = obj_rsp.ack;
      hit = obj_rsp.hit;
      rd  = obj_rsp.rdata;
      // Released fields are scrambled so a stale value is never mistaken for a live one
      obj_req.wr    = 1'b0;
      obj_req.rd    = 1'b0;
      obj_req.index = ~idx;
      obj_req.wdata = ~wd;
   endtask
endmodule

// ---- tb/test_touch_probe_position_latch.sv ----
`timescale 1ns/1ps
`include "tpl_params.svh"

module test_touch_probe_position_latch;
   logic                  core_clk;
   logic                  rst;
   logic [3:0]            latch_pins;
   logic [3:0]            idle_v;
   logic [7:0]            cfg;
   logic                  enc_zero;
   logic                  homing_active;
   logic signed [31:0]    fb_position;
   tpl_pkg::tpl_obj_req_t obj_req;
   tpl_pkg::tpl_obj_rsp_t obj_rsp;
   logic [15:0]           probe_control;
   logic [15:0]           probe_state;
   logic signed [31:0]    pos_one;
   logic signed [31:0]    pos_two;
   logic [1:0]            sel1;
   logic                  pol1;
   logic                  pol2;
   logic [3:0]            m1;
   logic [3:0]            m2;
   logic [31:0]           exp1;
   logic [31:0]           exp2;
   logic [31:0]           junk;
   logic                  tog;
   int                    bad_count;
   int                    checked;
   int                    cycles = 0;

   tpl_latch uut (
      .core_clk                 (core_clk),
      .rst                      (rst),
      .latch_pins               (latch_pins),
      .latch_input_config_param (cfg),
      .enc_zero                 (enc_zero),
      .homing_active            (homing_active),
      .fb_position              (fb_position),
      .obj_req                  (obj_req),
      .obj_rsp                  (obj_rsp),
      .probe_control            (probe_control),
      .probe_state              (probe_state),
      .captured_position_one    (pos_one),
      .captured_position_two    (pos_two)
   );

   tpl_master_model master (
      .core_clk (core_clk),
      .obj_req  (obj_req),
      .obj_rsp  (obj_rsp)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [7:0] st(input logic en, input logic lat, input logic t);
      return {t, 5'h00, lat, en};
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Every access must be answered one cycle later
   task automatic obj(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      input logic exp_hit, output logic [31:0] rd);
      logic ack;
      logic hit;
      master.access(wr, idx, wd, ack, hit, rd);
      chk("ack", {31'h0, ack}, 32'h1);
      chk("hit", {31'h0, hit}, {31'h0, exp_hit});
   endtask

   // One event on the masked pins and/or the zero pulse; the position seen at that edge is returned
   task automatic fire(input logic [3:0] m, input logic z, output logic [31:0] c);
      @(negedge core_clk);
      latch_pins  = idle_v ^ m;
      enc_zero    = z;
      fb_position = $urandom;
      c           = fb_position;
      @(negedge core_clk);
      latch_pins  = idle_v;
      enc_zero    = 1'b0;
      fb_position = $urandom;
      @(negedge core_clk);
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         give_verdict();
      end
   end

   initial begin
      bad_count = 0;
      checked = 0;
      rst = 1'b1;
      junk = $urandom(43);
      sel1 = 2'($urandom);
      pol1 = 1'($urandom);
      pol2 = 1'($urandom);
      cfg = {1'b0, sel1 ^ 2'h1, pol2, 1'b0, sel1, pol1};
      m1 = 4'h1 << sel1;
      m2 = 4'h1 << (sel1 ^ 2'h1);
      idle_v = (pol1 ? m1 : 4'h0) | (pol2 ? m2 : 4'h0);
      latch_pins = idle_v;
      enc_zero = 1'b0;
      homing_active = 1'b0;
      fb_position = $urandom;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      // Reset values, unknown read, refused write
      obj(1'b0, `TPL_IDX_CTRL, 32'h0, 1'b1, junk);
      chk("ctrl", junk, 32'h0);
      obj(1'b0, `TPL_IDX_STATUS, 32'h0, 1'b1, junk);
      chk("state", junk, 32'h0);
      obj(1'b0, 16'h60bb, 32'h0, 1'b0, junk);
      chk("unknown", junk, 32'h0);
      obj(1'b1, `TPL_IDX_STATUS, 32'hffff, 1'b0, junk);
      chk("ctrl", {16'h0, probe_control}, 32'h0);
      $display("test reset done");
      // Single trigger on latch input one
      obj(1'b1, `TPL_IDX_CTRL, 32'h0001, 1'b1, junk);
      fire(m1, 1'b0, exp1);
      chk("pos1", pos_one, exp1);
      obj(1'b0, `TPL_IDX_POS1, 32'h0, 1'b1, junk);
      chk("pos1 obj", junk, exp1);
      chk("state lo", {24'h0, probe_state[7:0]}, {24'h0, st(1'b1, 1'b1, 1'b1)});
      fire(m1, 1'b0, junk);
      chk("pos1 single", pos_one, exp1);
      chk("state lo", {24'h0, probe_state[7:0]}, {24'h0, st(1'b1, 1'b1, 1'b1)});
      obj(1'b1, `TPL_IDX_CTRL, 32'h0000, 1'b1, junk);
      chk("state off", {16'h0, probe_state}, 32'h0);
      chk("pos1 kept", pos_one, exp1);
      $display("test single done");
      // Zero pulse source: pin edges must not capture
      obj(1'b1, `TPL_IDX_CTRL, 32'h0005, 1'b1, junk);
      fire(m1 | m2, 1'b0, junk);
      chk("pos1 src", pos_one, exp1);
      fire(4'h0, 1'b1, exp1);
      chk("pos1 zero", pos_one, exp1);
      $display("test zero done");
      // Channel two continuous beside channel one single
      obj(1'b1, `TPL_IDX_CTRL, 32'h0000, 1'b1, junk);
      obj(1'b1, `TPL_IDX_CTRL, 32'h0301, 1'b1, junk);
      fire(m1 | m2, 1'b0, exp2);
      exp1 = exp2;
      chk("pos1 both", pos_one, exp2);
      chk("pos2 both", pos_two, exp2);
      tog = 1'b1;
      repeat (5) begin
         fire(m1 | m2, 1'($urandom), exp2);
         tog = ~tog;
         chk("pos2 cont", pos_two, exp2);
         chk("state hi", {24'h0, probe_state[15:8]}, {24'h0, st(1'b1, 1'b1, tog)});
      end
      fire(4'h0, 1'b1, junk);
      chk("pos2 zero", pos_two, exp2);
      chk("pos1 held", pos_one, exp1);
      obj(1'b0, `TPL_IDX_POS2, 32'h0, 1'b1, junk);
      chk("pos2 obj", junk, exp2);
      $display("test dual done");
      // Homing switches channel one off; the master keeps away from it meanwhile
      obj(1'b1, `TPL_IDX_CTRL, 32'h0000, 1'b1, junk);
      obj(1'b1, `TPL_IDX_CTRL, 32'h0103, 1'b1, junk);
      fire(m1 | m2, 1'b0, exp2);
      chk("pos2 single", pos_two, exp2);
      fire(m1 | m2, 1'b0, exp1);
      chk("pos1 cont", pos_one, exp1);
      chk("pos2 single", pos_two, exp2);
      @(negedge core_clk);
      homing_active = 1'b1;
      @(negedge core_clk);
      homing_active = 1'b0;
      chk("ctrl", {16'h0, probe_control}, 32'h0102);
      chk("state lo", {24'h0, probe_state[7:0]}, 32'h0);
      fire(m1, 1'b0, junk);
      chk("pos1 homed", pos_one, exp1);
      $display("test homing done");
      give_verdict();
   end
endmodule
